// >>> hdl/bra_agen.sv
// X write address generator pointer update with bit-reversed modifier
// assumes the execution logic presents one request per cycle at most and
// keeps the software ordering limits after control register writes
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module bra_agen
   import bra_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [3:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [15:0] o_reg_rdata,
   input wire logic i_ea_req,
   input wire logic [3:0] i_ea_ptr_num,
   input wire logic [15:0] i_ea_ptr_val,
   input wire bra_mode_t i_ea_mode,
   input wire logic i_ea_word,
   input wire logic i_ea_write,
   input wire logic [15:0] i_ea_offset,
   output logic o_ea_valid,
   output logic [15:0] o_ea,
   output logic o_ptr_wb,
   output logic [3:0] o_ptr_num,
   output logic [15:0] o_ptr_nxt,
   output logic o_rev_used,
   output logic o_circ_apply
);
   logic x_circular_enable;
   logic [3:0] x_circular_pointer_select;
   logic [3:0] reverse_pointer_select;
   logic reverse_enable;
   logic [14:0] reverse_modifier;
   logic [15:0] rev_sum;
   logic [15:0] rev_mask;
   logic [15:0] step;
   logic mode_inc;
   logic mode_dec;
   logic mode_pre;
   logic modifying;
   logic rev_hit;
   logic circ_hit;
   logic [15:0] norm_nxt;
   logic [15:0] ptr_nxt;
   logic [15:0] ea_nxt;
   logic valid_r;
   logic [15:0] ea_r;
   logic wb_r;
   logic [3:0] num_r;
   logic [15:0] ptr_r;
   logic rev_r;
   logic circ_r;
   logic [15:0] mask_r;

   bra_regs u_regs (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_addr(i_reg_addr),
      .i_wdata(i_reg_wdata),
      .i_wr(i_reg_wr),
      .i_rd(i_reg_rd),
      .o_rdata(o_reg_rdata),
      .o_x_circular_enable(x_circular_enable),
      .o_x_circular_pointer_select(x_circular_pointer_select),
      .o_reverse_pointer_select(reverse_pointer_select),
      .o_reverse_enable(reverse_enable),
      .o_reverse_modifier(reverse_modifier)
   );

   bra_rev_add u_rev_add (
      .i_ptr(i_ea_ptr_val),
      .i_mod(reverse_modifier),
      .o_sum(rev_sum),
      .o_mask(rev_mask)
   );

   // decode addressing mode
   always_comb begin
      mode_inc = 1'b0;
      mode_dec = 1'b0;
      mode_pre = 1'b0;
      unique case (i_ea_mode)
         BRA_MODE_DIRECT: begin
            mode_pre = 1'b0;
         end
         BRA_MODE_POST_INC: begin
            mode_inc = 1'b1;
         end
         BRA_MODE_PRE_INC: begin
            mode_inc = 1'b1;
            mode_pre = 1'b1;
         end
         BRA_MODE_POST_DEC: begin
            mode_dec = 1'b1;
         end
         BRA_MODE_PRE_DEC: begin
            mode_dec = 1'b1;
            mode_pre = 1'b1;
         end
         BRA_MODE_OFFSET: begin
            mode_pre = 1'b0;
         end
         default: begin
            mode_pre = 1'b0;
         end
      endcase
   end

   assign modifying = mode_inc | mode_dec;
   assign step = i_ea_word ? BRA_WORD_STEP : BRA_BYTE_STEP;

   // reversal qualifies on enable, pointer, mode, size and write path
   assign rev_hit = reverse_enable
      && (i_ea_ptr_num == reverse_pointer_select)
      && mode_inc
      && i_ea_word
      && i_ea_write;

   // circular correction yields to reversal on writes, kept on reads
   assign circ_hit = x_circular_enable
      && (i_ea_ptr_num == x_circular_pointer_select)
      && modifying
      && !rev_hit;

   always_comb begin
      norm_nxt = i_ea_ptr_val;
      if (mode_inc) begin
         norm_nxt = i_ea_ptr_val + step;
      end else if (mode_dec) begin
         norm_nxt = i_ea_ptr_val - step;
      end
   end

   assign ptr_nxt = rev_hit ? rev_sum : norm_nxt;

   always_comb begin
      ea_nxt = i_ea_ptr_val;
      if (i_ea_mode == BRA_MODE_OFFSET) begin
         ea_nxt = i_ea_ptr_val + i_ea_offset;
      end else if (mode_pre) begin
         ea_nxt = ptr_nxt;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         valid_r <= 1'b0;
      end else begin
         valid_r <= i_ea_req;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ea_r <= 16'h0000;
         wb_r <= 1'b0;
         num_r <= 4'h0;
         ptr_r <= 16'h0000;
         rev_r <= 1'b0;
         circ_r <= 1'b0;
         mask_r <= 16'h0000;
      end else if (i_ea_req) begin
         ea_r <= ea_nxt;
         wb_r <= modifying;
         num_r <= i_ea_ptr_num;
         ptr_r <= ptr_nxt;
         rev_r <= rev_hit;
         circ_r <= circ_hit;
         mask_r <= rev_mask;
      end else begin
         wb_r <= 1'b0;
         rev_r <= 1'b0;
         circ_r <= 1'b0;
      end
   end

   assign o_ea_valid = valid_r;
   assign o_ea = ea_r;
   assign o_ptr_wb = wb_r;
   assign o_ptr_num = num_r;
   assign o_ptr_nxt = ptr_r;
   assign o_rev_used = rev_r;
   assign o_circ_apply = circ_r;

   sequence rev_req_s;
      i_ea_req && reverse_enable && i_ea_mode == BRA_MODE_POST_INC && i_ea_word
         && i_ea_write && i_ea_ptr_num == reverse_pointer_select;
   endsequence

   sequence rev_16w_zero_s;
      rev_req_s ##0 (reverse_modifier == BRA_MOD_16W && i_ea_ptr_val[4:0] == 5'h00);
   endsequence

   sequence rev_16w_eight_s;
      rev_req_s ##0 (reverse_modifier == BRA_MOD_16W && i_ea_ptr_val[4:0] == 5'h10);
   endsequence

   sequence read_circ_s;
      i_ea_req && x_circular_enable && !i_ea_write && i_ea_mode == BRA_MODE_POST_INC
         && i_ea_ptr_num == x_circular_pointer_select;
   endsequence

   sel_ptr_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_rev_used |-> o_ptr_num == $past(reverse_pointer_select))
      else $error("reversal applied to a pointer that is not selected");

   rev_enable_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_rev_used |-> $past(reverse_enable))
      else $error("reversal applied while disabled");

   rev_mode_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_rev_used |-> ($past(i_ea_mode) == BRA_MODE_POST_INC
         || $past(i_ea_mode) == BRA_MODE_PRE_INC))
      else $error("reversal applied in a non increment mode");

   rev_word_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_rev_used |-> $past(i_ea_word))
      else $error("reversal applied to a byte access");

   rev_write_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_rev_used |-> $past(i_ea_write) && o_ptr_wb)
      else $error("reversal applied on the read path");

   rev_taken_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      rev_req_s |=> o_rev_used && o_ea_valid && o_ea == $past(i_ea_ptr_val))
      else $error("qualifying write did not use reversal");

   seq_first_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      rev_16w_zero_s |=> o_ptr_nxt == ($past(i_ea_ptr_val) | 16'h0010))
      else $error("word 0 did not step to word 8");

   seq_second_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      rev_16w_eight_s |=> o_ptr_nxt == {$past(i_ea_ptr_val[15:5]), 5'h08})
      else $error("word 8 did not step to word 4");

   keep_bit0_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_rev_used |-> o_ptr_nxt[0] == $past(i_ea_ptr_val[0]))
      else $error("reversal changed pointer bit 0");

   upper_16w_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_rev_used && $past(reverse_modifier) == BRA_MOD_16W
         |-> o_ptr_nxt[15:5] == $past(i_ea_ptr_val[15:5]))
      else $error("16-word buffer changed bits above 4");

   pivot_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_rev_used |-> ((o_ptr_nxt ^ $past(i_ea_ptr_val)) & ~mask_r) == 16'h0000)
      else $error("reversal changed bits above the pivot");

   circ_write_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_rev_used |-> !o_circ_apply)
      else $error("circular correction alongside reversal on write");

   circ_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      read_circ_s |=> o_circ_apply && !o_rev_used)
      else $error("read lost circular correction");

   normal_inc_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_ea_req && i_ea_mode == BRA_MODE_POST_INC && !i_ea_word
         |=> !o_rev_used && o_ptr_nxt == $past(i_ea_ptr_val) + BRA_BYTE_STEP)
      else $error("byte increment not normal");
endmodule

// >>> hdl/bra_pkg.sv
// constants, field layout and mode codes of the bit-reversed write address modifier
// assumes a 16-bit data path, a plain register port and one core clock
package bra_pkg;
   localparam logic [3:0] BRA_ADDR_MODE_CTRL = 4'h0;
   localparam logic [3:0] BRA_ADDR_REV_CTRL = 4'h1;
   localparam int BRA_XCIRC_EN_BIT = 15;
   localparam int BRA_YCIRC_EN_BIT = 14;
   localparam int BRA_REV_SEL_HI = 11;
   localparam int BRA_REV_SEL_LO = 8;
   localparam int BRA_XCIRC_SEL_HI = 3;
   localparam int BRA_XCIRC_SEL_LO = 0;
   localparam int BRA_REV_EN_BIT = 15;
   localparam int BRA_REV_MOD_HI = 14;
   localparam int BRA_REV_MOD_LO = 0;
   localparam logic [15:0] BRA_MODE_CTRL_RST = 16'h0000;
   localparam logic [15:0] BRA_REV_CTRL_RST = 16'h0000;
   localparam logic [15:0] BRA_MODE_CTRL_WMASK = 16'hCFFF;
   localparam logic [15:0] BRA_WORD_STEP = 16'h0002;
   localparam logic [15:0] BRA_BYTE_STEP = 16'h0001;
   localparam logic [14:0] BRA_MOD_16W = 15'h0008;
   typedef enum logic [2:0] {
      BRA_MODE_DIRECT = 3'b000,
      BRA_MODE_POST_INC = 3'b001,
      BRA_MODE_PRE_INC = 3'b010,
      BRA_MODE_POST_DEC = 3'b011,
      BRA_MODE_PRE_DEC = 3'b100,
      BRA_MODE_OFFSET = 3'b101
   } bra_mode_t;
endpackage

// >>> hdl/bra_rev_add.sv
// reverse-carry adder of pointer and shifted modifier, limited to the pivot and below
// assumes a power-of-two modifier; purely combinational
`timescale 1ns/1ps
module bra_rev_add
   import bra_pkg::*;
(
   input wire logic [15:0] i_ptr,
   input wire logic [14:0] i_mod,
   output logic [15:0] o_sum,
   output logic [15:0] o_mask
);
   logic [14:0] p_rev;
   logic [14:0] m_rev;
   logic [14:0] s_rev;
   logic [14:0] s_fld;
   logic [14:0] m_fld;
   // mirror word-address bits so a plain add carries toward lower bits
   for (genvar i = 0; i < 15; i++) begin : g_mirror
      assign p_rev[i] = i_ptr[15 - i];
      assign m_rev[i] = i_mod[14 - i];
      assign s_fld[i] = s_rev[14 - i];
   end
   assign s_rev = p_rev + m_rev;
   // field below and at the pivot; empty for a zero modifier
   assign m_fld = (i_mod == 15'h0000) ? 15'h0000 : (i_mod | (i_mod - 15'h0001));
   // bit 0 kept, bits above pivot kept, so no page carry
   assign o_sum = {(i_ptr[15:1] & ~m_fld) | (s_fld & m_fld), i_ptr[0]};
   assign o_mask = {m_fld, 1'b0};
endmodule

// >>> hdl/bra_regs.sv
// addressing mode control and reverse addressing control registers
// assumes one-cycle strobes, never both at once; read data stand one cycle
`timescale 1ns/1ps
module bra_regs
   import bra_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   output logic o_x_circular_enable,
   output logic [3:0] o_x_circular_pointer_select,
   output logic [3:0] o_reverse_pointer_select,
   output logic o_reverse_enable,
   output logic [14:0] o_reverse_modifier
);
   logic [15:0] mode_ctrl_r;
   logic [15:0] rev_ctrl_r;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mode_ctrl_r <= BRA_MODE_CTRL_RST;
      end else if (i_wr && i_addr == BRA_ADDR_MODE_CTRL) begin
         mode_ctrl_r <= i_wdata & BRA_MODE_CTRL_WMASK;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rev_ctrl_r <= BRA_REV_CTRL_RST;
      end else if (i_wr && i_addr == BRA_ADDR_REV_CTRL) begin
         rev_ctrl_r <= i_wdata;
      end
   end

   // unmapped addresses and idle cycles read zero
   always_comb begin
      rdata_nxt = 16'h0000;
      if (i_rd) begin
         unique case (i_addr)
            BRA_ADDR_MODE_CTRL: begin
               rdata_nxt = mode_ctrl_r;
            end
            BRA_ADDR_REV_CTRL: begin
               rdata_nxt = rev_ctrl_r;
            end
            default: begin
               rdata_nxt = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;
   assign o_x_circular_enable = mode_ctrl_r[BRA_XCIRC_EN_BIT];
   assign o_x_circular_pointer_select = mode_ctrl_r[BRA_XCIRC_SEL_HI:BRA_XCIRC_SEL_LO];
   assign o_reverse_pointer_select = mode_ctrl_r[BRA_REV_SEL_HI:BRA_REV_SEL_LO];
   assign o_reverse_enable = rev_ctrl_r[BRA_REV_EN_BIT];
   assign o_reverse_modifier = rev_ctrl_r[BRA_REV_MOD_HI:BRA_REV_MOD_LO];
endmodule

// >>> verif/bra_ptr_model.sv
// pointer register file of the execution side, with writeback forwarding
// assumes one core clock and pointer writebacks from the address generator
`timescale 1ns/1ps
module bra_ptr_model (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_ld,
   input wire logic [3:0] i_num,
   input wire logic [15:0] i_ld_val,
   input wire logic i_wb,
   input wire logic [3:0] i_wb_num,
   input wire logic [15:0] i_nxt,
   output logic [15:0] o_ptr_val
);
   logic [15:0] ptr_r [16];
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int i = 0; i < 16; i++) ptr_r[i] <= 16'h0000;
      end else begin
         if (i_wb) ptr_r[i_wb_num] <= i_nxt;
         if (i_ld) ptr_r[i_num] <= i_ld_val;
      end
   end
   // back-to-back requests see the pointer just written back
   assign o_ptr_val = (i_wb && i_wb_num == i_num) ? i_nxt : ptr_r[i_num];
endmodule

// >>> verif/bra_agen_tb.sv
// self-checking bench for the bit-reversed write address generator
// assumes the pointer file model on the far side and a 100 MHz core clock
`timescale 1ns/1ps
module bra_agen_tb
   import bra_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ea_req = 1'b0;
   logic [3:0] ea_num = 4'h0;
   bra_mode_t ea_mode = BRA_MODE_DIRECT;
   logic ea_word = 1'b0;
   logic ea_write = 1'b0;
   logic [15:0] ea_offset = 16'h0000;
   logic ld = 1'b0;
   logic [15:0] ld_val = 16'h0000;
   logic [15:0] reg_rdata, ea, ptr_nxt, ptr_val;
   logic [3:0] ptr_num;
   logic ea_valid, ptr_wb, rev_used, circ_apply;
   logic [15:0] mode_sh = 16'h0000;
   logic [15:0] rev_sh = 16'h0000;
   logic [3:0] sel = 4'h0;
   int err_total = 0;
   int comparisons = 0;

   always #5 clk = ~clk;

   bra_agen i_dut (.i_core_clk(clk), .i_nrst(rst_n), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
      .i_ea_req(ea_req), .i_ea_ptr_num(ea_num), .i_ea_ptr_val(ptr_val), .i_ea_mode(ea_mode),
      .i_ea_word(ea_word), .i_ea_write(ea_write), .i_ea_offset(ea_offset),
      .o_ea_valid(ea_valid), .o_ea(ea), .o_ptr_wb(ptr_wb), .o_ptr_num(ptr_num),
      .o_ptr_nxt(ptr_nxt), .o_rev_used(rev_used), .o_circ_apply(circ_apply));
   bra_ptr_model i_ptrs (.i_core_clk(clk), .i_nrst(rst_n), .i_ld(ld), .i_num(ea_num),
      .i_ld_val(ld_val), .i_wb(ptr_wb), .i_wb_num(ptr_num), .i_nxt(ptr_nxt),
      .o_ptr_val(ptr_val));

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] expv);
      comparisons++;
      if (seen !== expv) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, expv, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // reverse-carry addition: carries move toward bit 1, bit 0 is left alone
   function automatic logic [15:0] rev_add(input logic [15:0] p, input logic [15:0] m);
      logic c;
      c = 1'b0;
      for (int i = 15; i >= 1; i--) {c, p[i]} = p[i] + m[i] + c;
      return p;
   endfunction

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      ea_req <= 1'b0;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] x);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", reg_rdata, x);
      @(posedge clk);
      #1;
      chk("rdata_idle", reg_rdata, 16'h0000);
   endtask

   task automatic send(input logic [3:0] n, input bra_mode_t m, input logic w, input logic wt);
      @(posedge clk);
      ld <= 1'b0;
      ea_req <= 1'b1;
      ea_num <= n;
      ea_mode <= m;
      ea_word <= w;
      ea_write <= wt;
      ea_offset <= 16'($urandom);
   endtask

   // expectation from the inputs taken at each edge and the shadowed registers
   always @(posedge clk) begin : mon
      logic rv, inc, wbe, cir, tk;
      logic [15:0] st, nx, e;
      logic [3:0] nm;
      inc = ea_mode inside {BRA_MODE_POST_INC, BRA_MODE_PRE_INC};
      wbe = inc || ea_mode inside {BRA_MODE_POST_DEC, BRA_MODE_PRE_DEC};
      rv = rev_sh[15] && ea_num == mode_sh[11:8] && inc && ea_word && ea_write;
      st = ea_word ? 16'h0002 : 16'h0001;
      nx = rv ? rev_add(ptr_val, {rev_sh[14:0], 1'b0}) : inc ? ptr_val + st :
         wbe ? ptr_val - st : ptr_val;
      e = (ea_mode == BRA_MODE_OFFSET) ? ptr_val + ea_offset :
         (ea_mode inside {BRA_MODE_PRE_INC, BRA_MODE_PRE_DEC}) ? nx : ptr_val;
      cir = mode_sh[15] && ea_num == mode_sh[3:0] && wbe && !rv;
      if (reg_wr && reg_addr == 4'h0) mode_sh = reg_wdata & 16'hCFFF;
      if (reg_wr && reg_addr == 4'h1) rev_sh = reg_wdata;
      tk = ea_req;
      nm = ea_num;
      #1;
      if (tk) begin
         chk("ea_valid", ea_valid, 16'h0001);
         chk("rev_used", rev_used, rv);
         chk("ptr_wb", ptr_wb, wbe);
         chk("ea", ea, e);
         chk("circ_apply", circ_apply, cir);
         if (wbe) chk("ptr_nxt", ptr_nxt, nx);
         chk("ptr_num", ptr_num, nm);
      end else begin
         chk("idle", {12'h000, ea_valid, ptr_wb, rev_used, circ_apply}, 16'h0000);
      end
   end

   // run needs well under 10 us; the limit leaves ample margin
   initial begin
      #100000;
      err_total++;
      test_done();
   end

   initial begin
      void'($urandom(32'h08D8));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(4'h0, 16'h0000);
      rd(4'h1, 16'h0000);
      wr(4'h0, 16'hFFFF);
      wr(4'h7, 16'h1234);
      rd(4'h0, 16'hCFFF);
      rd(4'h7, 16'h0000);
      wr(4'h1, 16'h8008);
      wr(4'h0, 16'h0100);
      rd(4'h1, 16'h8008);
      @(posedge clk);
      ld <= 1'b1;
      ea_num <= 4'h1;
      ld_val <= 16'h5A00;
      // sixteen back-to-back word writes walk the mirrored order, then wrap
      for (int k = 0; k < 17; k++) begin
         if (k < 16) begin
            send(4'h1, BRA_MODE_POST_INC, 1'b1, 1'b1);
         end else begin
            @(posedge clk);
            ea_req <= 1'b0;
         end
         #1;
         if (k > 0) chk("mirror", ptr_nxt, {11'h2D0, k[0], k[1], k[2], k[3], 1'b0});
      end
      for (int n = 0; n < 400; n++) begin
         if (n % 40 == 0) begin
            sel = 4'($urandom);
            wr(4'h0, {2'($urandom), 2'h0, sel, 4'($urandom),
               ($urandom_range(0, 1) ? sel : 4'($urandom))});
            wr(4'h1, {1'($urandom), 15'(15'h0001 << $urandom_range(0, 14))});
            repeat (2) @(posedge clk);
         end
         if ($urandom_range(0, 7) == 0) begin
            @(posedge clk);
            ea_req <= 1'b0;
            ld <= 1'b1;
            ld_val <= 16'($urandom);
         end
         send($urandom_range(0, 1) ? sel : 4'($urandom), bra_mode_t'($urandom_range(0, 7)),
            1'($urandom), 1'($urandom));
      end
      @(posedge clk);
      ea_req <= 1'b0;
      repeat (3) @(posedge clk);
      test_done();
   end
endmodule
